/* File: hw/failsafe_defs.svh */
/*
 * Constants of the transceiver fail-safe controller: register offsets,
 * field positions, reset values and default time-out counts.
 * Assumes a 25 MHz pclk and is included by its bare name.
 */
`ifndef FAILSAFE_DEFS_SVH
`define FAILSAFE_DEFS_SVH

// ****************************************************************
// Register map, byte addresses on APB
// ****************************************************************
`define FS_CTRL_OFFSET 12'h000
`define FS_STATUS_OFFSET 12'h004
`define FS_ADDR_W 12

// ****************************************************************
// Field positions
// ****************************************************************
`define FS_CTRL_CLAMP_EN_BIT 0
`define FS_CTRL_TXD_TO_EN_BIT 1
`define FS_CTRL_RESET 32'h00000003
`define FS_ST_MODE_LSB 0
`define FS_ST_UV_BIT 4
`define FS_ST_OT_BIT 5
`define FS_ST_TXD_TO_BIT 6
`define FS_ST_CLAMP_BIT 7
`define FS_ST_WAKE_BIT 8
`define FS_ST_RXD_BIT 9

// ****************************************************************
// Timing: times in ns, counts derived from the clock period
// ****************************************************************
`define FS_CLK_PERIOD_NS 40
`define FS_WAKE_FILTER_NS 1000
`define FS_WAKE_DOM_LIMIT_NS 80000
`define FS_CLAMP_DETECT_NS 2000
`define FS_TXD_DOM_LIMIT_NS 80000
`define FS_WAKE_FILTER_CYC ((`FS_WAKE_FILTER_NS + `FS_CLK_PERIOD_NS - 1) / `FS_CLK_PERIOD_NS)
`define FS_WAKE_DOM_LIMIT_CYC ((`FS_WAKE_DOM_LIMIT_NS + `FS_CLK_PERIOD_NS - 1) / `FS_CLK_PERIOD_NS)
`define FS_CLAMP_DETECT_CYC ((`FS_CLAMP_DETECT_NS + `FS_CLK_PERIOD_NS - 1) / `FS_CLK_PERIOD_NS)
`define FS_TXD_DOM_LIMIT_CYC ((`FS_TXD_DOM_LIMIT_NS + `FS_CLK_PERIOD_NS - 1) / `FS_CLK_PERIOD_NS)

`endif

/* File: hw/failsafe_pkg.sv */
/*
 * Types shared by the fail-safe controller files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package failsafe_pkg;

  // ****************************************************************
  // Operating modes, one-hot
  // ****************************************************************
  typedef enum logic [3:0] {
    MODE_UNPOWERED = 4'b0001,
    MODE_STANDBY = 4'b0010,
    MODE_SILENT = 4'b0100,
    MODE_NORMAL = 4'b1000
  } fs_mode_t;

endpackage

/* File: hw/fs_timer_if.sv */
/*
 * Run request and expiry flag between the controller and a time-out
 * counter. Assumes both ends share pclk.
 */
`timescale 1ns/1ps

interface fs_timer_if;
  logic run;
  logic expired;
  modport owner (output run, input expired);
  modport counter (input run, output expired);
endinterface

/* File: hw/fs_timeout_counter.sv */
/*
 * Saturating time-out counter: counts while run is high, clears when it
 * falls, flags expiry once LIMIT cycles have passed.
 * Assumes run is synchronous to pclk.
 */
`timescale 1ns/1ps

module fs_timeout_counter #(
  parameter int LIMIT = 16
) (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  fs_timer_if.counter tmr // Run request in, expiry out.
);

  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] CMAX = CW'(LIMIT);

  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  wire at_limit = (count_reg == CMAX);

  // Dropping run clears the count, so each new dominant phase starts fresh.
  assign count_next = !tmr.run ? '0 : (at_limit ? count_reg : count_reg + CW'(1));
  assign tmr.expired = tmr.run && at_limit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule

/* File: hw/can_transceiver_failsafe_ctrl.sv */
/*
 * Fail-safe supervision of a high-speed CAN transceiver: mode decode,
 * undervoltage shutdown, standby wake filter and time-out, over-temperature
 * driver release, transmit dominant time-out and receive clamp detection,
 * with an APB register slave for control and status.
 * Assumes all pin and comparator inputs are synchronous to pclk.
 */
`timescale 1ns/1ps
`include "failsafe_defs.svh"

module can_transceiver_failsafe_ctrl #(
  parameter int WAKE_FILTER_CYC = `FS_WAKE_FILTER_CYC,
  parameter int WAKE_DOM_LIMIT_CYC = `FS_WAKE_DOM_LIMIT_CYC,
  parameter int CLAMP_DETECT_CYC = `FS_CLAMP_DETECT_CYC,
  parameter int TXD_DOM_LIMIT_CYC = `FS_TXD_DOM_LIMIT_CYC
) (
  input wire logic pclk, // System clock, 25 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [31:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  input wire logic [3:0] pstrb, // APB byte strobes.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address or on a write to status.
  input wire logic txd, // Transmit data from controller.
  input wire logic txd_driven, // High while the controller drives txd.
  input wire logic standby_select, // Standby select level.
  input wire logic standby_select_driven, // High while standby_select is driven.
  input wire logic silent_select_n, // Silent select, active low.
  input wire logic silent_select_n_driven, // High while silent_select_n is driven.
  input wire logic uv_core, // Core supply undervoltage flag.
  input wire logic uv_io, // I/O supply undervoltage flag.
  input wire logic overtemp, // Over-temperature indication.
  input wire logic fast_bus_comparator, // High when fast comparator sees dominant.
  input wire logic low_power_wake_comparator, // High when wake comparator sees dominant.
  input wire logic rxd_level, // Actual level read back on the receive pin.
  output logic rxd_out, // Receive data output, low is dominant.
  output logic bus_dominant, // Drive the bus dominant.
  output logic driver_enable, // Bus transmitter enabled.
  output logic fast_cmp_enable, // Fast comparator powered.
  output logic wake_cmp_enable, // Wake comparator powered.
  output failsafe_pkg::fs_mode_t mode // Current operating mode.
);
  import failsafe_pkg::*;

  // ****************************************************************
  // Pin defaults and mode decode
  // ****************************************************************
  wire txd_eff = txd_driven ? txd : 1'b1;
  wire standby_select_eff = standby_select_driven ? standby_select : 1'b1;
  wire sil_n_eff = silent_select_n_driven ? silent_select_n : 1'b1;
  wire uv = uv_core | uv_io;

  fs_mode_t mode_reg;
  fs_mode_t mode_next;
  logic [31:0] ctrl_reg;
  logic clamp_reg;
  logic ot_reg;
  logic txd_to_reg;
  logic armed_reg;
  logic rxd_reg;
  logic drv_reg;
  logic dom_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  wire in_standby = (mode_reg == MODE_STANDBY);
  wire in_active = (mode_reg == MODE_NORMAL) || (mode_reg == MODE_SILENT);
  wire clamp_en = ctrl_reg[`FS_CTRL_CLAMP_EN_BIT];
  wire txd_to_en = ctrl_reg[`FS_CTRL_TXD_TO_EN_BIT];

  // A request for normal with transmit low keeps the present mode; from
  // unpowered the device waits in standby instead.
  wire want_normal = !standby_select_eff && sil_n_eff;
  wire hold_mode = want_normal && !txd_eff;
  wire fallback_silent = (mode_reg == MODE_UNPOWERED) ? 1'b0 : (mode_reg == MODE_SILENT);

  always_comb begin
    mode_next = mode_reg;
    if (uv) begin
      mode_next = MODE_UNPOWERED;
    end else if (standby_select_eff) begin
      mode_next = MODE_STANDBY;
    end else if (!sil_n_eff) begin
      mode_next = MODE_SILENT;
    end else if (hold_mode) begin
      case (mode_reg)
        MODE_UNPOWERED: mode_next = MODE_STANDBY;
        MODE_STANDBY: mode_next = MODE_STANDBY;
        MODE_SILENT: mode_next = MODE_SILENT;
        MODE_NORMAL: mode_next = clamp_reg ? MODE_SILENT : MODE_NORMAL;
        default: mode_next = MODE_STANDBY;
      endcase
    end else begin
      mode_next = clamp_reg ? MODE_SILENT : MODE_NORMAL;
    end
  end

  // ****************************************************************
  // Time-out counters
  // ****************************************************************
  fs_timer_if wake_filt_t ();
  fs_timer_if wake_dom_t ();
  fs_timer_if clamp_t ();
  fs_timer_if txd_t ();

  // The wake comparator only counts a dominant phase that began after a
  // recessive one, so a bus already dominant at standby entry is ignored.
  wire wake_dom = low_power_wake_comparator && !uv;
  wire wake_run = in_standby && armed_reg && wake_dom;
  assign wake_filt_t.run = wake_run;
  assign wake_dom_t.run = wake_run;
  assign clamp_t.run = in_active && clamp_en && fast_bus_comparator && rxd_level;
  assign txd_t.run = txd_to_en && !txd_eff;

  fs_timeout_counter #(.LIMIT(WAKE_FILTER_CYC)) u_wake_filt (
    .pclk(pclk),
    .presetn(presetn),
    .tmr(wake_filt_t)
  );
  fs_timeout_counter #(.LIMIT(WAKE_DOM_LIMIT_CYC)) u_wake_dom (
    .pclk(pclk),
    .presetn(presetn),
    .tmr(wake_dom_t)
  );
  fs_timeout_counter #(.LIMIT(CLAMP_DETECT_CYC)) u_clamp (
    .pclk(pclk),
    .presetn(presetn),
    .tmr(clamp_t)
  );
  fs_timeout_counter #(.LIMIT(TXD_DOM_LIMIT_CYC)) u_txd (
    .pclk(pclk),
    .presetn(presetn),
    .tmr(txd_t)
  );

  // ****************************************************************
  // Fault flags and outputs
  // ****************************************************************
  wire wake_req = wake_filt_t.expired && !wake_dom_t.expired;
  // Set wins over clear on the clamp, over-temperature and time-out flags below.
  wire clamp_next = clamp_t.expired ||
    (clamp_reg && in_active && rxd_level);
  wire ot_next = overtemp || (ot_reg && !txd_eff);
  wire txd_to_next = txd_t.expired || (txd_to_reg && !txd_eff);
  wire armed_next = in_standby && (!wake_dom || armed_reg);
  wire rxd_next = (mode_next == MODE_UNPOWERED) ? 1'b1 :
    in_standby ? !wake_req : !fast_bus_comparator;
  wire drv_next = (mode_next == MODE_NORMAL) && !ot_next && !txd_to_next && !clamp_next;
  wire dom_next = drv_next && !txd_eff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= MODE_UNPOWERED;
      clamp_reg <= 1'b0;
      ot_reg <= 1'b0;
      txd_to_reg <= 1'b0;
      armed_reg <= 1'b0;
      rxd_reg <= 1'b1;
      drv_reg <= 1'b0;
      dom_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      clamp_reg <= clamp_next;
      ot_reg <= ot_next;
      txd_to_reg <= txd_to_next;
      armed_reg <= armed_next;
      rxd_reg <= rxd_next;
      drv_reg <= drv_next;
      dom_reg <= dom_next;
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  wire sel_ctrl = (paddr[`FS_ADDR_W-1:0] == `FS_CTRL_OFFSET) && (paddr[31:`FS_ADDR_W] == '0);
  wire sel_status = (paddr[`FS_ADDR_W-1:0] == `FS_STATUS_OFFSET) &&
    (paddr[31:`FS_ADDR_W] == '0);
  wire setup = psel && !penable && !pready_reg;
  wire wr_ctrl = psel && penable && pready_reg && pwrite && sel_ctrl;

  logic [31:0] status_word;
  always_comb begin
    status_word = '0;
    status_word[`FS_ST_MODE_LSB +: 4] = mode_reg;
    status_word[`FS_ST_UV_BIT] = uv;
    status_word[`FS_ST_OT_BIT] = ot_reg;
    status_word[`FS_ST_TXD_TO_BIT] = txd_to_reg;
    status_word[`FS_ST_CLAMP_BIT] = clamp_reg;
    status_word[`FS_ST_WAKE_BIT] = wake_req;
    status_word[`FS_ST_RXD_BIT] = rxd_reg;
  end

  wire [31:0] rd_word = sel_ctrl ? ctrl_reg : (sel_status ? status_word : 32'h00000000);
  logic [31:0] ctrl_next;
  always_comb begin
    ctrl_next = ctrl_reg;
    for (int i = 0; i < 4; i++) begin
      if (pstrb[i]) begin
        ctrl_next[8*i +: 8] = pwdata[8*i +: 8];
      end
    end
  end

  // One wait-free access phase: ready rises for the cycle after setup.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `FS_CTRL_RESET;
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup && !(sel_ctrl || (sel_status && !pwrite));
      prdata_reg <= (setup && !pwrite) ? rd_word : 32'h00000000;
      if (wr_ctrl) begin
        ctrl_reg <= ctrl_next;
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign mode = mode_reg;
  assign rxd_out = rxd_reg;
  assign driver_enable = drv_reg;
  assign bus_dominant = dom_reg;
  // Registered so that the ports come from flip-flops; the wake enable tracks uv one
  // cycle late, the fast enable changes on the same edge as the mode register.
  logic wcmp_reg;
  logic fcmp_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wcmp_reg <= 1'b0;
      fcmp_reg <= 1'b0;
    end else begin
      wcmp_reg <= !uv;
      fcmp_reg <= (mode_next == MODE_NORMAL) || (mode_next == MODE_SILENT);
    end
  end
  assign wake_cmp_enable = wcmp_reg;
  assign fast_cmp_enable = fcmp_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_uv_shutdown: assert property (uv |=> mode_reg == MODE_UNPOWERED && !driver_enable)
    else $error("undervoltage did not switch the device off");
  a_wake_cmp_off: assert property (uv |=> !wake_cmp_enable)
    else $error("wake comparator enabled during undervoltage");
  a_wake_cmp_on: assert property (!uv |=> wake_cmp_enable)
    else $error("wake comparator disabled without undervoltage");
  a_fast_cmp_on: assert property (in_active |-> fast_cmp_enable)
    else $error("fast comparator off in normal or silent mode");
  a_standby_select_ignored: assert property (uv && standby_select_eff |=> mode_reg != MODE_STANDBY)
    else $error("standby select honoured during undervoltage");
  a_wake_timeout: assert property (in_standby && wake_dom_t.expired &&
    mode_next == MODE_STANDBY |=> rxd_out)
    else $error("receive output not high after wake dominant limit");
  a_wake_request: assert property (in_standby && wake_req && mode_next == MODE_STANDBY
    |=> !rxd_out)
    else $error("wake request not shown on receive output");
  a_ot_hold: assert property (ot_reg && !txd_eff |=> ot_reg && !driver_enable)
    else $error("drivers re-enabled while transmit input low");
  a_clamp_silent: assert property ($rose(clamp_reg) |-> !driver_enable ##1
    mode_reg != MODE_NORMAL)
    else $error("clamp did not force silent mode");
  a_clamp_release: assert property (clamp_reg && !rxd_level |=> !clamp_reg)
    else $error("clamp state kept with receive pin low");
  a_normal_txd: assert property ($rose(mode_reg == MODE_NORMAL) |-> $past(txd_eff))
    else $error("normal mode entered with transmit input low");
  a_txd_timeout: assert property (txd_t.expired |=> txd_to_reg && !bus_dominant)
    else $error("transmit dominant time-out did not release the bus");
  a_standby_decode: assert property (!uv && standby_select_eff |=> mode_reg == MODE_STANDBY)
    else $error("standby select high did not give standby");

endmodule

/* File: bench/can_ctrl_model.sv */
/*
 * Behavioural model of the CAN protocol controller that drives the mode and
 * transmit pins of the transceiver and watches its receive output.
 * Assumes the bench gives it commands synchronous to pclk.
 */
`timescale 1ns/1ps

module can_ctrl_model (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Reset, active low.
  input wire logic cmd_standby, // Bench asks for standby.
  input wire logic cmd_silent, // Bench asks for silent.
  input wire logic cmd_txd, // Bench transmit level.
  input wire logic cmd_float, // Bench asks to release all pins.
  input wire logic rxd_out, // Receive output of the transceiver.
  output logic txd, // Transmit data pin.
  output logic txd_driven, // High while txd is driven.
  output logic standby_select, // Standby select pin.
  output logic standby_select_driven, // High while standby_select is driven.
  output logic silent_select_n, // Silent select pin, active low.
  output logic silent_select_n_driven, // High while silent_select_n is driven.
  output logic wake_seen // Wake request seen while in standby.
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {txd, standby_select, silent_select_n} <= 3'h7;
      {txd_driven, standby_select_driven, silent_select_n_driven} <= 3'h7;
      wake_seen <= 1'b0;
    end else if (cmd_float) begin
      // Released pins carry a toggling pattern, so only the driven flags may decide.
      {txd, standby_select, silent_select_n} <= ~{txd, standby_select, silent_select_n};
      {txd_driven, standby_select_driven, silent_select_n_driven} <= 3'h0;
    end else begin
      {txd_driven, standby_select_driven, silent_select_n_driven} <= 3'h7;
      standby_select <= cmd_standby;
      txd <= cmd_standby | cmd_txd;
      silent_select_n <= cmd_standby | ~cmd_silent;
      wake_seen <= cmd_standby & (wake_seen | ~rxd_out);
    end
  end
endmodule

/* File: bench/tb_can_transceiver_failsafe_ctrl.sv */
/*
 * Self-checking bench of the transceiver fail-safe controller: APB register
 * access, mode decode, time-outs, supply and temperature faults, clamping.
 * Assumes the controller model drives the mode pins; small time-out counts.
 */
`timescale 1ns/1ps
`include "failsafe_defs.svh"

module tb_can_transceiver_failsafe_ctrl;
  import failsafe_pkg::*;
`define CHECK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
  $display("CHECK FAILED at %0t: got %h expected %h", $time, (a), (b)); end end
  localparam int WF = 3;
  localparam int WD = 8;
  localparam int CD = 4;
  localparam int TD = 8;
  localparam logic [31:0] A_CTRL = {20'h00000, `FS_CTRL_OFFSET};
  localparam logic [31:0] A_STAT = {20'h00000, `FS_STATUS_OFFSET};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata, rd, d, rnd;
  logic [3:0] pstrb;
  logic txd, txd_driven, standby_select, standby_select_driven;
  logic silent_select_n, silent_select_n_driven, uv_core, uv_io, overtemp;
  logic fast_bus_comparator, low_power_wake_comparator, rxd_level, rxd_out;
  logic bus_dominant, driver_enable, fast_cmp_enable, wake_cmp_enable, t;
  logic cmd_standby, cmd_silent, cmd_txd, cmd_float, clamp_force, wake_seen;
  fs_mode_t mode, prev, exp_m;
  int errors, total_checks, i, k;
  integer seed;
  logic [2:0] rows [6] = '{3'b101, 3'b000, 3'b001, 3'b011, 3'b010, 3'b001};

  // Readback of the receive pin; clamp_force models a pin stuck high.
  assign rxd_level = clamp_force ? 1'b1 : rxd_out;

  can_transceiver_failsafe_ctrl #(.WAKE_FILTER_CYC(WF), .WAKE_DOM_LIMIT_CYC(WD),
    .CLAMP_DETECT_CYC(CD), .TXD_DOM_LIMIT_CYC(TD)) can_transceiver_failsafe_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .txd(txd), .txd_driven(txd_driven), .standby_select(standby_select),
    .standby_select_driven(standby_select_driven), .silent_select_n(silent_select_n),
    .silent_select_n_driven(silent_select_n_driven), .uv_core(uv_core), .uv_io(uv_io),
    .overtemp(overtemp), .fast_bus_comparator(fast_bus_comparator),
    .low_power_wake_comparator(low_power_wake_comparator), .rxd_level(rxd_level),
    .rxd_out(rxd_out), .bus_dominant(bus_dominant), .driver_enable(driver_enable),
    .fast_cmp_enable(fast_cmp_enable), .wake_cmp_enable(wake_cmp_enable), .mode(mode));

  can_ctrl_model can_ctrl_model_inst (.pclk(pclk), .presetn(presetn),
    .cmd_standby(cmd_standby), .cmd_silent(cmd_silent), .cmd_txd(cmd_txd),
    .cmd_float(cmd_float), .rxd_out(rxd_out), .txd(txd), .txd_driven(txd_driven),
    .standby_select(standby_select), .standby_select_driven(standby_select_driven),
    .silent_select_n(silent_select_n), .silent_select_n_driven(silent_select_n_driven),
    .wake_seen(wake_seen));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic fs_mode_t decode_mode(logic s, logic sil, logic tx, fs_mode_t cur);
    if (s) return MODE_STANDBY;
    if (sil) return MODE_SILENT;
    if (!tx) return (cur == MODE_UNPOWERED) ? MODE_STANDBY : cur;
    return MODE_NORMAL;
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                     input logic [3:0] st);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for ready.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic go_mode(input logic s, input logic sil, input logic tx);
    prev = mode;
    cmd_standby <= s;
    cmd_silent <= sil;
    cmd_txd <= tx;
    tick(3);
    exp_m = decode_mode(s, sil, tx, prev);
    `CHECK(mode, exp_m)
    `CHECK(fast_cmp_enable, exp_m == MODE_NORMAL || exp_m == MODE_SILENT)
  endtask

  task finish_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // Clock, watchdog and test sequence
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  initial begin
    #400000;
    errors++;
    finish_test;
  end

  initial begin
    seed = 32'h57ad;
    errors = 0;
    total_checks = 0;
    {presetn, psel, penable, pwrite, uv_core, uv_io, overtemp} = 7'h00;
    {paddr, pwdata, pstrb} = '0;
    {fast_bus_comparator, low_power_wake_comparator, clamp_force, cmd_float} = 4'h0;
    {cmd_standby, cmd_silent, cmd_txd} = 3'b001;
    tick(2);
    `CHECK(mode, MODE_UNPOWERED)
    `CHECK({rxd_out, driver_enable, wake_cmp_enable, pready}, 4'h8)
    presetn <= 1'b1;
    apb(1'b0, A_CTRL, 32'h0, 4'h0);
    `CHECK(rd, `FS_CTRL_RESET)
    d = $random(seed);
    apb(1'b1, A_CTRL, d, 4'hf);
    apb(1'b0, A_CTRL, 32'h0, 4'h0);
    `CHECK(rd, d)
    apb(1'b1, A_CTRL, ~d, 4'h0);
    apb(1'b0, A_CTRL, 32'h0, 4'h0);
    `CHECK(rd, d)
    apb(1'b1, A_CTRL, `FS_CTRL_RESET, 4'hf);
    apb(1'b0, 32'h00000008, 32'h0, 4'h0);
    `CHECK({err, rd}, {1'b1, 32'h0})
    apb(1'b1, A_STAT, 32'hffffffff, 4'hf);
    `CHECK(err, 1'b1)
    $display("test registers done");
    for (i = 0; i < 14; i++) begin
      rnd = $random(seed);
      if (i < 6) go_mode(rows[i][2], rows[i][1], rows[i][0]);
      else go_mode(rnd[0], rnd[1], 1'b1);
    end
    cmd_float <= 1'b1;
    tick(3);
    `CHECK(mode, MODE_STANDBY)
    cmd_float <= 1'b0;
    go_mode(1'b0, 1'b0, 1'b1);
    for (i = 0; i < 40; i++) begin
      @(posedge pclk);
      t = txd;
      rnd = $random(seed);
      cmd_txd <= (i % 4 == 3) ? 1'b1 : rnd[0];
      #1 `CHECK(bus_dominant, ~t)
    end
    $display("test modes done");
    cmd_txd <= 1'b0;
    tick(TD);
    `CHECK(driver_enable, 1'b1)
    tick(4);
    `CHECK({driver_enable, bus_dominant}, 2'b00)
    apb(1'b0, A_STAT, 32'h0, 4'h0);
    `CHECK(rd[`FS_ST_TXD_TO_BIT], 1'b1)
    cmd_txd <= 1'b1;
    tick(3);
    `CHECK(driver_enable, 1'b1)
    // Transmit goes low before the temperature clears, so the latch must hold.
    overtemp <= 1'b1;
    cmd_txd <= 1'b0;
    tick(3);
    `CHECK(driver_enable, 1'b0)
    overtemp <= 1'b0;
    tick(4);
    `CHECK(driver_enable, 1'b0)
    cmd_txd <= 1'b1;
    tick(3);
    `CHECK(driver_enable, 1'b1)
    apb(1'b1, A_CTRL, 32'h0, 4'hf);
    cmd_txd <= 1'b0;
    tick(TD + 4);
    `CHECK({driver_enable, bus_dominant}, 2'b11)
    cmd_txd <= 1'b1;
    apb(1'b1, A_CTRL, `FS_CTRL_RESET, 4'hf);
    $display("test faults done");
    for (k = 0; k < 3; k++) begin
      uv_core <= (k != 1);
      uv_io <= (k != 0);
      tick(3);
      `CHECK({mode, driver_enable, rxd_out}, {MODE_UNPOWERED, 2'b01})
      `CHECK(wake_cmp_enable, 1'b0)
      cmd_standby <= 1'b1;
      tick(3);
      `CHECK(mode, MODE_UNPOWERED)
      cmd_standby <= 1'b0;
      uv_core <= 1'b0;
      tick(3);
      `CHECK(mode, (k == 0) ? MODE_NORMAL : MODE_UNPOWERED)
      uv_io <= 1'b0;
      tick(3);
      `CHECK({mode, wake_cmp_enable}, {MODE_NORMAL, 1'b1})
    end
    $display("test supply done");
    go_mode(1'b1, 1'b0, 1'b1);
    low_power_wake_comparator <= 1'b1;
    tick(WF);
    `CHECK(rxd_out, 1'b1)
    tick(3);
    `CHECK(rxd_out, 1'b0)
    tick(WD - WF);
    `CHECK({rxd_out, wake_seen, mode}, {2'b11, MODE_STANDBY})
    low_power_wake_comparator <= 1'b0;
    tick(2);
    low_power_wake_comparator <= 1'b1;
    tick(WF + 3);
    `CHECK(rxd_out, 1'b0)
    low_power_wake_comparator <= 1'b0;
    go_mode(1'b0, 1'b0, 1'b1);
    $display("test wake done");
    fast_bus_comparator <= 1'b1;
    clamp_force <= 1'b1;
    tick(CD);
    `CHECK(mode, MODE_NORMAL)
    tick(4);
    `CHECK({mode, driver_enable}, {MODE_SILENT, 1'b0})
    apb(1'b0, A_STAT, 32'h0, 4'h0);
    `CHECK(rd[`FS_ST_CLAMP_BIT], 1'b1)
    clamp_force <= 1'b0;
    tick(4);
    `CHECK(mode, MODE_NORMAL)
    fast_bus_comparator <= 1'b0;
    $display("test clamp done");
    finish_test;
  end
endmodule
